// File: include/ds_cfg.svh
// constants for the data-space decoder and nonvolatile byte store
// assumes inclusion by bare name from the package and design files
`ifndef DS_CFG_SVH
`define DS_CFG_SVH
// ==========================================
// data space map
`define DS_REG_LAST   16'h001f
`define DS_IO_BASE    16'h0020
`define DS_IO_LAST    16'h005f
`define DS_EXT_LAST   16'h00ff
`define DS_SRAM_BASE  16'h0100
`define DS_SRAM_LAST  16'h08ff
`define DS_SHORT_LAST 16'h003f
// ==========================================
// nonvolatile store registers in the I/O region
`define NVM_CR_ADDR   16'h003f
`define NVM_DR_ADDR   16'h0040
`define NVM_ARL_ADDR  16'h0041
`define NVM_ARH_ADDR  16'h0042
`define NVM_RE_BIT    0
`define NVM_WS_BIT    1
`define NVM_MWE_BIT   2
`define NVM_RD_STALL  3'h4
`define NVM_WR_STALL  3'h2
`define NVM_MWE_WIN   3'h4
`define NVM_WTIME_DEF 16'h03e8
// ==========================================
// pointer registers and register map
`define PTR_BASE_IDX  5'h1a
`define APB_WTIME     12'h000
`define APB_STATUS    12'h004
`define APB_IPTR      12'h008
`endif

// File: include/ds_pkg.sv
// types shared by the data-space decoder
// assumes ds_cfg.svh sits on the include path
`include "ds_cfg.svh"
package ds_pkg;
  typedef enum logic [1:0] {
    RG_REG  = 2'b00,
    RG_IO   = 2'b01,
    RG_EXT  = 2'b10,
    RG_SRAM = 2'b11
  } region_e;
  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } ptr_sel_e;
  typedef enum logic [1:0] {
    PM_PLAIN   = 2'b00,
    PM_POSTINC = 2'b01,
    PM_PREDEC  = 2'b10,
    PM_DISP    = 2'b11
  } ptr_mode_e;
endpackage

// File: rtl/byte_ram.sv
// single-port byte memory with registered read data
// assumes one clock; contents are not reset
module byte_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2048,
  parameter int AW    = 11
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             we,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] rdata_q
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= mem[addr];
    end
  end
endmodule

// File: rtl/data_space_decode.sv
// data-space decoder, pointer unit and nonvolatile byte store access
// assumes a cpu core on the same clock and an APB master for setup
//
// Implementation choices: register access over APB and the register offsets.
`include "ds_cfg.svh"
module data_space_decode #(
  parameter int SRAM_AW    = 11,
  parameter int NVM_AW     = 10,
  parameter int IPTR_W     = 14,
  parameter logic [15:0] WRITE_CYCLES = `NVM_WTIME_DEF
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               por_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               cpu_req,
  input  wire logic               cpu_wr,
  input  wire logic               cpu_short_io,
  input  wire logic [15:0]        cpu_addr,
  input  wire logic [7:0]         cpu_wdata,
  output logic      [7:0]         cpu_rdata_q,
  output logic                    cpu_done_q,
  output logic                    cpu_err_q,
  output logic                    cpu_stall_q,
  output ds_pkg::region_e         region_q,
  input  wire logic               ptr_req,
  input  wire ds_pkg::ptr_sel_e   ptr_sel,
  input  wire ds_pkg::ptr_mode_e  ptr_mode,
  input  wire logic [5:0]         ptr_disp,
  output logic      [15:0]        ptr_addr_q,
  output logic                    ptr_valid_q,
  input  wire logic               ip_step,
  output logic      [IPTR_W-1:0]  instruction_pointer
);
  import ds_pkg::*;

  // ==========================================
  // state
  logic [7:0]        rf_q [32];
  logic              acc_busy_q;
  logic [15:0]       acc_addr_q;
  logic [2:0]        stall_cnt_q;
  logic              rd_pend_q;
  logic [2:0]        mwe_cnt_q;
  logic [NVM_AW-1:0] nvm_byte_address;
  logic [7:0]        nvm_byte_data;
  logic              wr_busy_q;
  logic [15:0]       wr_timer_q;
  logic [7:0]        wr_cnt_q;
  logic [15:0]       wtime_q;
  logic [7:0]        sram_rdata;
  logic [7:0]        nvm_rdata;

  // ==========================================
  // address decode
  region_e     dec_region;
  logic        dec_err;
  logic [15:0] eff_addr;
  logic [7:0]  io_rdata;
  logic [7:0]  nvm_control_reg;
  logic        take;
  logic        cpu_wr_io;
  logic        rd_start;
  logic        wr_start;
  logic        ws_req;
  logic        mwe_set;

  always_comb
  begin
    // short path carries a 6-bit I/O number, shifted into data space
    eff_addr = cpu_short_io ? (cpu_addr + `DS_IO_BASE) : cpu_addr;
    dec_err  = cpu_short_io ? (cpu_addr > `DS_SHORT_LAST)
                            : (cpu_addr > `DS_SRAM_LAST);
    if (eff_addr <= `DS_REG_LAST)
    begin
      dec_region = RG_REG;
    end
    else if (eff_addr <= `DS_IO_LAST)
    begin
      dec_region = RG_IO;
    end
    else if (eff_addr <= `DS_EXT_LAST)
    begin
      dec_region = RG_EXT;
    end
    else
    begin
      dec_region = RG_SRAM;
    end
  end

  assign nvm_control_reg = {5'h00, (mwe_cnt_q != 3'h0), wr_busy_q, 1'b0};

  always_comb
  begin
    unique case (eff_addr)
      `NVM_CR_ADDR:  io_rdata = nvm_control_reg;
      `NVM_DR_ADDR:  io_rdata = nvm_byte_data;
      `NVM_ARL_ADDR: io_rdata = nvm_byte_address[7:0];
      `NVM_ARH_ADDR: io_rdata = {6'h00, nvm_byte_address[9:8]};
      default:       io_rdata = 8'h00;
    endcase
  end

  assign take      = cpu_req && !acc_busy_q && (stall_cnt_q == 3'h0);
  assign cpu_wr_io = take && cpu_wr && !dec_err && (dec_region == RG_IO);
  assign ws_req    = cpu_wr_io && (eff_addr == `NVM_CR_ADDR)
                     && cpu_wdata[`NVM_WS_BIT];
  // strobe only counts while the master enable window is still open
  assign wr_start  = ws_req && (mwe_cnt_q != 3'h0) && !wr_busy_q;
  assign rd_start  = cpu_wr_io && (eff_addr == `NVM_CR_ADDR)
                     && cpu_wdata[`NVM_RE_BIT] && !wr_busy_q && !wr_start;
  assign mwe_set   = cpu_wr_io && (eff_addr == `NVM_CR_ADDR) && cpu_wdata[`NVM_MWE_BIT];

  // ==========================================
  // access sequencing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_busy_q  <= 1'b0;
      acc_addr_q  <= 16'h0000;
      cpu_done_q  <= 1'b0;
      cpu_err_q   <= 1'b0;
      cpu_rdata_q <= 8'h00;
      region_q    <= RG_REG;
    end
    else
    begin
      cpu_done_q <= 1'b0;
      cpu_err_q  <= 1'b0;
      if (acc_busy_q)
      begin
        // second SRAM cycle: read data out of the array register
        acc_busy_q  <= 1'b0;
        cpu_done_q  <= 1'b1;
        cpu_rdata_q <= sram_rdata;
      end
      else if (take)
      begin
        region_q <= dec_region;
        if (dec_err)
        begin
          cpu_done_q  <= 1'b1;
          cpu_err_q   <= 1'b1;
          cpu_rdata_q <= 8'h00;
        end
        else if (dec_region == RG_SRAM)
        begin
          acc_busy_q <= 1'b1;
          acc_addr_q <= eff_addr;
        end
        else
        begin
          cpu_done_q <= 1'b1;
          unique case (dec_region)
            RG_REG:  cpu_rdata_q <= rf_q[eff_addr[4:0]];
            RG_IO:   cpu_rdata_q <= io_rdata;
            default: cpu_rdata_q <= 8'h00;
          endcase
        end
      end
    end
  end

  logic [15:0] sram_off;
  assign sram_off = (acc_busy_q ? acc_addr_q : eff_addr) - `DS_SRAM_BASE;

  byte_ram #(
    .WIDTH (8),
    .DEPTH (1 << SRAM_AW),
    .AW    (SRAM_AW)
  ) u_sram (
    .clk     (pclk),
    .rst_n   (presetn),
    .we      (take && cpu_wr && !dec_err && (dec_region == RG_SRAM)),
    .addr    (sram_off[SRAM_AW-1:0]),
    .wdata   (cpu_wdata),
    .rdata_q (sram_rdata)
  );

  // ==========================================
  // working registers and pointer unit
  logic [4:0]  ptr_lo;
  logic [15:0] ptr_base;
  logic [15:0] ptr_use;
  logic [15:0] ptr_new;

  always_comb
  begin
    ptr_lo   = `PTR_BASE_IDX + {2'b00, ptr_sel, 1'b0};
    ptr_base = {rf_q[ptr_lo + 5'h01], rf_q[ptr_lo]};
    ptr_use  = ptr_base;
    ptr_new  = ptr_base;
    unique case (ptr_mode)
      PM_PLAIN:   ptr_use = ptr_base;
      PM_POSTINC: ptr_new = ptr_base + 16'h0001;
      PM_PREDEC:
      begin
        ptr_use = ptr_base - 16'h0001;
        ptr_new = ptr_use;
      end
      PM_DISP:    ptr_use = (ptr_sel == PTR_X) ? ptr_base
                          : ptr_base + {10'h000, ptr_disp};
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 32; i++)
      begin
        rf_q[i] <= 8'h00;
      end
      ptr_addr_q  <= 16'h0000;
      ptr_valid_q <= 1'b0;
    end
    else
    begin
      ptr_valid_q <= ptr_req;
      if (take && cpu_wr && !dec_err && (dec_region == RG_REG))
      begin
        rf_q[eff_addr[4:0]] <= cpu_wdata;
      end
      // pointer write-back wins over a same-cycle store to its bytes
      if (ptr_req)
      begin
        ptr_addr_q         <= ptr_use;
        rf_q[ptr_lo]         <= ptr_new[7:0];
        rf_q[ptr_lo + 5'h01] <= ptr_new[15:8];
      end
    end
  end

  // ==========================================
  // nonvolatile store: registers, guard and stall
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nvm_byte_address <= '0;
      nvm_byte_data    <= 8'h00;
      mwe_cnt_q        <= 3'h0;
      stall_cnt_q      <= 3'h0;
      cpu_stall_q      <= 1'b0;
      rd_pend_q        <= 1'b0;
    end
    else
    begin
      if (cpu_wr_io && !wr_busy_q)
      begin
        unique case (eff_addr)
          `NVM_DR_ADDR:  nvm_byte_data <= cpu_wdata;
          `NVM_ARL_ADDR: nvm_byte_address[7:0] <= cpu_wdata;
          `NVM_ARH_ADDR: nvm_byte_address[9:8] <= cpu_wdata[1:0];
          default: ;
        endcase
      end
      if (wr_start)
      begin
        mwe_cnt_q <= 3'h0;
      end
      else if (cpu_wr_io && (eff_addr == `NVM_CR_ADDR) && cpu_wdata[`NVM_MWE_BIT])
      begin
        mwe_cnt_q <= `NVM_MWE_WIN;
      end
      else if (mwe_cnt_q != 3'h0)
      begin
        mwe_cnt_q <= mwe_cnt_q - 3'h1;
      end
      if (rd_start)
      begin
        stall_cnt_q <= `NVM_RD_STALL;
        cpu_stall_q <= 1'b1;
        rd_pend_q   <= 1'b1;
      end
      else if (wr_start)
      begin
        stall_cnt_q <= `NVM_WR_STALL;
        cpu_stall_q <= 1'b1;
      end
      else if (stall_cnt_q != 3'h0)
      begin
        stall_cnt_q <= stall_cnt_q - 3'h1;
        cpu_stall_q <= (stall_cnt_q != 3'h1);
        if ((stall_cnt_q == 3'h1) && rd_pend_q)
        begin
          nvm_byte_data <= nvm_rdata;
          rd_pend_q     <= 1'b0;
        end
      end
    end
  end

  // write engine runs on power-on reset only so a chip reset cannot cut it
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      wr_busy_q  <= 1'b0;
      wr_timer_q <= 16'h0000;
      wr_cnt_q   <= 8'h00;
    end
    else if (wr_start)
    begin
      wr_busy_q  <= 1'b1;
      wr_timer_q <= wtime_q;
    end
    else if (wr_busy_q)
    begin
      wr_timer_q <= wr_timer_q - 16'h0001;
      if (wr_timer_q <= 16'h0001)
      begin
        wr_busy_q <= 1'b0;
        wr_cnt_q  <= wr_cnt_q + 8'h01;
      end
    end
  end

  byte_ram #(
    .WIDTH (8),
    .DEPTH (1 << NVM_AW),
    .AW    (NVM_AW)
  ) u_nvm (
    .clk     (pclk),
    .rst_n   (presetn),
    .we      (wr_start),
    .addr    (nvm_byte_address),
    .wdata   (nvm_byte_data),
    .rdata_q (nvm_rdata)
  );

  // ==========================================
  // APB slave and instruction pointer
  logic apb_acc;
  logic apb_wr;
  assign apb_acc = psel && penable && !pready;
  assign apb_wr  = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready <= apb_acc;
      if (apb_acc)
      begin
        pslverr <= 1'b0;
        unique case (paddr)
          `APB_WTIME:  prdata <= {16'h0000, wtime_q};
          `APB_STATUS: prdata <= {21'h000000, wr_busy_q, region_q, wr_cnt_q};
          `APB_IPTR:   prdata <= {{(32-IPTR_W){1'b0}}, instruction_pointer};
          default:
          begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wtime_q             <= WRITE_CYCLES;
      instruction_pointer <= '0;
    end
    else
    begin
      if (apb_wr && (paddr == `APB_WTIME))
      begin
        wtime_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
      if (apb_wr && (paddr == `APB_IPTR))
      begin
        instruction_pointer <= pwdata[IPTR_W-1:0];
      end
      else if (ip_step)
      begin
        instruction_pointer <= instruction_pointer + 1'b1;
      end
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_stall4;
    cpu_stall_q [*4] ##1 !cpu_stall_q;
  endsequence
  sequence s_stall2;
    cpu_stall_q [*2] ##1 !cpu_stall_q;
  endsequence

  chk_sram_latency: assert property (
    (take && !dec_err && dec_region == RG_SRAM) |=> !cpu_done_q ##1 cpu_done_q)
    else $error("sram access not done in two cycles");
  chk_reg_region: assert property (
    (take && !cpu_short_io && cpu_addr <= 16'h001f) |=> cpu_done_q && region_q == RG_REG)
    else $error("register file access misdecoded");
  chk_io_region: assert property (
    (take && !cpu_short_io && cpu_addr inside {[16'h0020:16'h005f]}) |=> region_q == RG_IO)
    else $error("standard io access misdecoded");
  chk_ext_region: assert property (
    (take && !cpu_short_io && cpu_addr inside {[16'h0060:16'h00ff]}) |=> region_q == RG_EXT)
    else $error("extended io access misdecoded");
  chk_short_path: assert property (
    (take && cpu_short_io) |=> cpu_err_q || region_q == RG_IO)
    else $error("short io path reached beyond standard io");
  chk_read_stall: assert property (rd_start |=> s_stall4)
    else $error("read stall not four cycles");
  chk_write_stall: assert property (wr_start |=> s_stall2)
    else $error("write stall not two cycles");
  chk_write_guard: assert property (wr_start |->
    $past(mwe_set) || $past(mwe_set, 2) || $past(mwe_set, 3) || $past(mwe_set, 4))
    else $error("unguarded write started");
  chk_busy_flag: assert property (wr_start |=> wr_busy_q && nvm_control_reg[1])
    else $error("busy flag not raised by write");
  chk_read_refuse: assert property (
    (cpu_wr_io && eff_addr == `NVM_CR_ADDR && cpu_wdata[`NVM_RE_BIT] && wr_busy_q)
    |=> !cpu_stall_q && $stable(nvm_byte_data))
    else $error("read accepted while write busy");
  chk_predec_use: assert property (
    (ptr_req && ptr_mode == PM_PREDEC) |=> ptr_addr_q == $past(ptr_base) - 16'h0001)
    else $error("pre-decrement address wrong");
endmodule

// File: tb/cpu_model.sv
// behavioural cpu core issuing data-space loads and stores
// assumes the decoder takes a request at an edge where stall is low
module cpu_model (
  input  wire logic        pclk,
  input  wire logic        cpu_stall_q,
  input  wire logic        cpu_done_q,
  output logic             cpu_req,
  output logic             cpu_wr,
  output logic             cpu_short_io,
  output logic      [15:0] cpu_addr,
  output logic      [7:0]  cpu_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  int t_take = 0;
  initial
  begin
    cpu_req = 1'b0;
    cpu_wr = 1'b0;
    cpu_short_io = 1'b0;
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  // ====================================================
  // one access at a time, in caller order; idle address and write-data lines show inverted values
  task automatic access(input logic wr, sh, input logic [15:0] a,
                        input logic [7:0] d, input int gap);
    int k;
    repeat (gap + 1) @(posedge pclk);
    cpu_req <= 1'b1;
    cpu_wr <= wr;
    cpu_short_io <= sh;
    cpu_addr <= a;
    cpu_wdata <= d;
    k = 0;
    do @(posedge pclk); while (cpu_stall_q !== 1'b0 && ++k < 20);
    t_take = cyc;
    cpu_req <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~d;
    k = 0;
    do @(posedge pclk); while (cpu_done_q !== 1'b1 && ++k < 20);
  endtask
endmodule

// File: tb/data_space_decode_eeprom_access_tb_top.sv
// self-checking bench for the data-space decoder
// assumes cpu_model as the core and an APB master in this module
module data_space_decode_eeprom_access_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ds_pkg::*;
  typedef struct {logic [31:0] v; logic [31:0] m; int x;} note_s;
  logic pclk = 0, presetn = 0, por_n = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic cpu_req, cpu_wr, cpu_short_io, cpu_done_q, cpu_err_q, cpu_stall_q;
  logic [15:0] cpu_addr, ptr_addr_q;
  logic [7:0] cpu_wdata, cpu_rdata_q, d1, d2, d4;
  region_e region_q;
  logic ptr_req = 0, ptr_valid_q, ip_step = 0;
  ptr_sel_e ptr_sel = PTR_X;
  ptr_mode_e ptr_mode = PM_PLAIN;
  logic [5:0] ptr_disp = 0, r6;
  logic [13:0] instruction_pointer;
  logic [15:0] at[10] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f, 16'h0060,
                          16'h00ff, 16'h0100, 16'h08ff, 16'h0900, 16'hffff};
  note_s q_cpu[$], q_apb[$], q_ptr[$], mn;
  int q_stl[$];
  int error_cnt = 0, checks = 0, sc = 0;
  always #25 pclk = ~pclk;
  data_space_decode dut_u (
    .pclk                (pclk),
    .presetn             (presetn),
    .por_n               (por_n),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .cpu_req             (cpu_req),
    .cpu_wr              (cpu_wr),
    .cpu_short_io        (cpu_short_io),
    .cpu_addr            (cpu_addr),
    .cpu_wdata           (cpu_wdata),
    .cpu_rdata_q         (cpu_rdata_q),
    .cpu_done_q          (cpu_done_q),
    .cpu_err_q           (cpu_err_q),
    .cpu_stall_q         (cpu_stall_q),
    .region_q            (region_q),
    .ptr_req             (ptr_req),
    .ptr_sel             (ptr_sel),
    .ptr_mode            (ptr_mode),
    .ptr_disp            (ptr_disp),
    .ptr_addr_q          (ptr_addr_q),
    .ptr_valid_q         (ptr_valid_q),
    .ip_step             (ip_step),
    .instruction_pointer (instruction_pointer)
  );
  cpu_model cpu_u (.pclk(pclk), .cpu_stall_q(cpu_stall_q), .cpu_done_q(cpu_done_q),
    .cpu_req(cpu_req), .cpu_wr(cpu_wr), .cpu_short_io(cpu_short_io),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata));
  // ====================================================
  // shared tasks
  task automatic cmp(input logic [31:0] g, e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task final_report;
    // a result that never showed up leaves its note behind
    error_cnt += q_cpu.size() + q_apb.size() + q_ptr.size() + q_stl.size();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [1:0] rgn(input logic [15:0] a);
    return a < 16'h20 ? 2'd0 : a < 16'h60 ? 2'd1 : a < 16'h100 ? 2'd2 : 2'd3;
  endfunction
  task automatic dop(input logic wr, sh, input logic [15:0] a,
                     input logic [7:0] d, e, cm);
    logic [15:0] ea;
    logic er;
    note_s n;
    ea = sh ? a + 16'h0020 : a;
    er = sh ? a > 16'h003f : a > 16'h08ff;
    n.v = {21'h0, rgn(ea), er, e};
    n.m = {21'h0, {2{~er}}, 1'b1, cm};
    n.x = (rgn(ea) == 2'd3 && !er) ? 2 : 1;
    q_cpu.push_back(n);
    cpu_u.access(wr, sh, a, d, $urandom_range(1));
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, e, m,
                     input logic er);
    int k;
    q_apb.push_back('{e, m, er});
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic ptr(input ptr_sel_e s, input ptr_mode_e md, input logic [5:0] dp,
                     input logic [15:0] e);
    q_ptr.push_back('{e, 32'hffff, 0});
    @(posedge pclk);
    ptr_req <= 1;
    ptr_sel <= s;
    ptr_mode <= md;
    ptr_disp <= dp;
    @(posedge pclk);
    ptr_req <= 0;
  endtask
  task automatic nset(input logic [9:0] a, input logic [7:0] d);
    dop(1, 0, 16'h41, a[7:0], 0, 0);
    dop(1, 0, 16'h42, {6'h0, a[9:8]}, 0, 0);
    dop(1, 0, 16'h40, d, 0, 0);
  endtask
  task automatic nwr(input logic [9:0] a, input logic [7:0] d);
    nset(a, d);
    q_stl.push_back(2);
    dop(1, 0, 16'h3f, 8'h04, 0, 0);
    dop(1, 0, 16'h3f, 8'h02, 0, 0);
  endtask
  task automatic nrd(input logic [9:0] a, input logic [7:0] e);
    nset(a, ~e);
    q_stl.push_back(4);
    dop(1, 0, 16'h3f, 8'h01, 0, 0);
    dop(0, 0, 16'h40, 0, e, 8'hff);
  endtask
  // ====================================================
  // result watchers
  always @(posedge pclk)
  begin
    if (pready === 1'b1 && q_apb.size() > 0)
    begin
      mn = q_apb.pop_front();
      cmp(prdata & mn.m, mn.v & mn.m);
      cmp({31'h0, pslverr}, mn.x);
    end
    if (cpu_done_q === 1'b1 && q_cpu.size() > 0)
    begin
      mn = q_cpu.pop_front();
      cmp({21'h0, region_q, cpu_err_q, cpu_rdata_q} & mn.m, mn.v & mn.m);
      cmp(cpu_u.cyc - cpu_u.t_take, mn.x);
    end
    if (ptr_valid_q === 1'b1 && q_ptr.size() > 0)
    begin
      mn = q_ptr.pop_front();
      cmp({16'h0, ptr_addr_q}, mn.v);
    end
    if (cpu_stall_q === 1'b1) sc <= sc + 1;
    else if (sc > 0)
    begin
      if (q_stl.size() > 0) cmp(sc, q_stl.pop_front());
      sc <= 0;
    end
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    final_report();
  end
  // ====================================================
  // main sequence
  initial
  begin
    void'($urandom(77322));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    por_n <= 1;
    apb(0, 12'h000, 0, 32'h3e8, '1, 0);
    apb(1, 12'h000, 0, 0, 0, 0);
    apb(0, 12'h000, 0, 32'h1, '1, 0);
    apb(1, 12'h000, 32'hc, 0, 0, 0);
    apb(1, 12'h00c, 32'h5, 32'h0, '1, 1);
    $display("test register bus done");
    foreach (at[i])
    begin
      d1 = 8'($urandom);
      dop(1, 0, at[i], d1, 0, 0);
      dop(0, 0, at[i], 0, rgn(at[i]) == 2'd2 ? 8'h00 : d1,
          (rgn(at[i]) != 2'd1 && at[i] < 16'h900) ? 8'hff : 8'h00);
    end
    dop(0, 1, 16'h001f, 0, 0, 0);
    dop(0, 1, 16'h0040, 0, 0, 0);
    $display("test map done");
    dop(1, 0, 16'd26, 8'h00, 0, 0);
    dop(1, 0, 16'd27, 8'h02, 0, 0);
    dop(1, 0, 16'd28, 8'h00, 0, 0);
    dop(1, 0, 16'd29, 8'h01, 0, 0);
    dop(1, 0, 16'd30, 8'h34, 0, 0);
    dop(1, 0, 16'd31, 8'h12, 0, 0);
    r6 = 6'($urandom);
    ptr(PTR_X, PM_PREDEC, 0, 16'h01ff);
    ptr(PTR_X, PM_POSTINC, 0, 16'h01ff);
    ptr(PTR_X, PM_DISP, 6'h05, 16'h0200);
    ptr(PTR_Y, PM_DISP, 6'h3f, 16'h013f);
    ptr(PTR_Z, PM_DISP, r6, 16'h1234 + r6);
    ptr(PTR_Z, PM_PREDEC, 0, 16'h1233);
    dop(0, 0, 16'd26, 0, 8'h00, 8'hff);
    dop(0, 0, 16'd27, 0, 8'h02, 8'hff);
    dop(0, 0, 16'd30, 0, 8'h33, 8'hff);
    $display("test pointer done");
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    nwr(10'h3ff, d1);
    dop(0, 0, 16'h3f, 0, 8'h02, 8'h02);
    dop(1, 0, 16'h3f, 8'h01, 0, 0);
    dop(0, 0, 16'h40, 0, d1, 8'hff);
    repeat (20) @(posedge pclk);
    dop(0, 0, 16'h3f, 0, 8'h00, 8'h02);
    nwr(10'h000, d2);
    repeat (20) @(posedge pclk);
    nrd(10'h3ff, d1);
    nrd(10'h000, d2);
    nset(10'h3ff, ~d1);
    dop(1, 0, 16'h3f, 8'h04, 0, 0);
    repeat (6) @(posedge pclk);
    dop(1, 0, 16'h3f, 8'h02, 0, 0);
    dop(1, 0, 16'h3f, 8'h02, 0, 0);
    repeat (20) @(posedge pclk);
    nrd(10'h3ff, d1);
    $display("test nonvolatile store done");
    ip_step <= 1;
    repeat (16387) @(posedge pclk);
    ip_step <= 0;
    @(posedge pclk);
    cmp({18'h0, instruction_pointer}, 32'h3);
    apb(0, 12'h008, 0, 32'h3, '1, 0);
    $display("test instruction pointer done");
    d4 = 8'($urandom);
    nwr(10'h155, d4);
    // let the write stall finish before the chip reset cuts in
    repeat (3) @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h004, 0, 32'h400, 32'hfffffc00, 0);
    repeat (1100) @(posedge pclk);
    nrd(10'h155, d4);
    $display("test reset during write done");
    repeat (2) @(posedge pclk);
    final_report();
  end
endmodule
